// >>> adc_iface_regs.svh
// timing counts, pin encodings and reset values of the converter interface
`ifndef ADC_IFACE_REGS_SVH
`define ADC_IFACE_REGS_SVH

// =====================================================================
// clock rates and conversion timing
`define REF_CLK_KHZ 20000
`define CONV_CLK_KHZ 2500
`define T_CONVERT_NS 8000
`define CONV_CLKS ((`T_CONVERT_NS * `CONV_CLK_KHZ) / 1000000)
`define CONV_HALF_DIV (`REF_CLK_KHZ / (2 * `CONV_CLK_KHZ))
`define STROBE_DELAY_CLKS 2

// =====================================================================
// serial word layout
`define SERIAL_BITS 16
`define LEAD_ZEROS 4'h0
`define RESULT_BITS 12

// =====================================================================
// format-select pin levels as seen by the level detector
`define FMT_WORD 2'h1
`define FMT_SER_GATED 2'h0
`define FMT_SER_FREE 2'h2

// =====================================================================
// reset values
`define RST_PIN_SYNC 6'h3F
`define RST_RESULT 12'h000

`endif

// >>> adc_iface_pkg.sv
// types shared by the converter interface modules
package adc_iface_pkg;

  // =====================================================================
  // conversion sequencer
  typedef enum logic {PH_IDLE, PH_BUSY} phase_t;

  // =====================================================================
  // host read strobes and format straps
  typedef struct packed {
    logic chip_select_n;
    logic read_n;
    logic high_byte_select;
    logic [1:0] format_select;
  } host_pins_t;

  // open-drain serial lines: level driven low and its enable
  typedef struct packed {
    logic serial_frame_strobe_n;
    logic serial_frame_strobe_oe;
    logic serial_clock;
    logic serial_clock_oe;
    logic serial_data_out;
    logic serial_data_oe;
  } serial_pins_t;

  // parallel data bus, low byte and upper nibble enabled apart
  typedef struct packed {
    logic [11:0] data;
    logic low_oe;
    logic high_oe;
  } data_bus_t;

endpackage : adc_iface_pkg

// >>> conv_clock_gen.sv
// conversion clock phase enables from the internal divider or an external pin
`timescale 1ns/1ps
`include "adc_iface_regs.svh"

module conv_clock_gen #(
  parameter int HALF_DIV = `CONV_HALF_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // clock source
  input wire logic ext_clock_select,
  input wire logic ext_conv_clock,
  // phase enables
  output logic rise_en,
  output logic fall_en
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic ext_prev;
    logic [7:0] cnt;
    logic level;
    logic rise;
    logic fall;
  } clkgen_t;

  clkgen_t st;
  clkgen_t next_st;

  // =====================================================================
  // divider or edge detector
  always_comb
  begin
    next_st = st;
    next_st.meta = {ext_clock_select, ext_conv_clock};
    next_st.sync = st.meta;
    next_st.ext_prev = st.sync[0];
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.sync[1])
    begin
      next_st.cnt = 8'h00;
      next_st.rise = st.sync[0] & ~st.ext_prev;
      next_st.fall = ~st.sync[0] & st.ext_prev;
    end
    else if (st.cnt == 8'(HALF_DIV - 1))
    begin
      next_st.cnt = 8'h00;
      next_st.level = ~st.level;
      next_st.rise = ~st.level;
      next_st.fall = st.level;
    end
    else
    begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign rise_en = st.rise;
  assign fall_en = st.fall;

endmodule : conv_clock_gen

// >>> result_hold.sv
// output holding register for the last completed conversion
`timescale 1ns/1ps
`include "adc_iface_regs.svh"

module result_hold #(
  parameter int WIDTH = `RESULT_BITS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // load side
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  // read side
  output logic [WIDTH-1:0] hold_data
);

  typedef struct packed {
    logic [WIDTH-1:0] word;
  } hold_t;

  hold_t st;
  hold_t next_st;

  // =====================================================================
  // changes only when a conversion completes
  always_comb
  begin
    next_st = st;
    if (load)
      next_st.word = load_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign hold_data = st.word;

endmodule : result_hold

// >>> adc_host_interface.sv
// digital interface of a 12-bit sampling converter: start, done, reads, serial
// =====================================================================
// Notes on behaviour
// - falling convert start puts track/hold into hold and starts converting
// - done output stays high from reset or a read until end, goes low at end
// - read returns result; coincident select and read falling releases done
// - byte or serial format: first read fall after conversion releases done
// - data bus released unless select and read are both low
// - select and read held low: bus shows old result until next end
// - select and read held low: done output stays low
// - word format: all twelve bits appear together on one read
// - word format: no serial output at all
// - byte format: first read gives byte picked by high-byte select
// - byte format: low eight bits, or upper four right-justified
// - serial word is four zeros then twelve bits, MSB first
// - frame strobe low within three clocks; first bit on next fall
// - serial clock free-running at one level, stops after frame at other
`timescale 1ns/1ps
`include "adc_iface_regs.svh"

module adc_host_interface #(
  parameter int CONV_CLKS = `CONV_CLKS,
  parameter int HALF_DIV = `CONV_HALF_DIV,
  parameter int STROBE_DELAY = `STROBE_DELAY_CLKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // conversion control pins
  input wire logic convert_start_n,
  input wire adc_iface_pkg::host_pins_t host_pins,
  // conversion clock source
  input wire logic ext_clock_select,
  input wire logic ext_conv_clock,
  // analog core
  input wire logic [11:0] analog_sample,
  output logic track_hold_hold,
  // host outputs
  output logic conversion_done_n,
  output adc_iface_pkg::data_bus_t data_bus,
  output adc_iface_pkg::serial_pins_t serial_pins
);

  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
    logic start_prev;
    logic read_prev;
    adc_iface_pkg::phase_t phase;
    logic [5:0] clk_cnt;
    logic [4:0] bit_cnt;
    logic [15:0] shreg;
    logic [11:0] sample;
    logic xmit;
    logic last_bit;
    logic sclk;
    logic load;
    logic hold;
    logic done_n;
    adc_iface_pkg::data_bus_t bus;
    adc_iface_pkg::serial_pins_t ser;
  } core_t;

  core_t st;
  core_t next_st;

  logic rise_en;
  logic fall_en;
  logic [11:0] result;

  // =====================================================================
  // helpers
  function automatic logic [7:0] byte_lane(input logic [11:0] word,
                                           input logic upper);
    if (upper)
      byte_lane = {4'h0, word[11:8]};
    else
      byte_lane = word[7:0];
  endfunction : byte_lane

  // one-cycle pulse when a synced active-low level goes low
  function automatic logic went_low(input logic now_n, input logic was_n);
    went_low = ~now_n & was_n;
  endfunction : went_low

  function automatic logic serial_fmt(input logic [1:0] fmt);
    serial_fmt = (fmt == `FMT_SER_GATED) || (fmt == `FMT_SER_FREE);
  endfunction : serial_fmt

  // =====================================================================
  // submodules
  conv_clock_gen #(
    .HALF_DIV(HALF_DIV)
  ) u_clk (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ext_clock_select(ext_clock_select),
    .ext_conv_clock(ext_conv_clock),
    .rise_en(rise_en),
    .fall_en(fall_en)
  );

  result_hold #(
    .WIDTH(`RESULT_BITS)
  ) u_hold (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(st.load),
    .load_data(st.sample),
    .hold_data(result)
  );

  // =====================================================================
  // sequencer, read decode and pin drivers
  always_comb
  begin
    logic start_n;
    logic cs_n;
    logic rd_n;
    logic hbs;
    logic [1:0] fmt;
    logic reading;
    logic read_fall;
    logic start_fall;
    logic ser;
    start_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    hbs = 1'b0;
    fmt = `FMT_WORD;
    reading = 1'b0;
    read_fall = 1'b0;
    start_fall = 1'b0;
    ser = 1'b0;
    next_st = st;
    next_st.meta = {convert_start_n, host_pins.chip_select_n,
                    host_pins.read_n, host_pins.high_byte_select,
                    host_pins.format_select};
    next_st.sync = st.meta;
    {start_n, cs_n, rd_n, hbs, fmt} = st.sync;
    ser = serial_fmt(fmt);
    reading = ~cs_n & ~rd_n;
    // edge only, so a read held low never releases done again
    read_fall = went_low(~reading, ~st.read_prev);
    start_fall = went_low(start_n, st.start_prev);
    next_st.read_prev = reading;
    next_st.start_prev = start_n;
    next_st.load = 1'b0;

    if (rise_en)
      next_st.sclk = 1'b1;
    if (fall_en)
      next_st.sclk = 1'b0;

    if (read_fall)
      next_st.done_n = 1'b1;

    case (st.phase)
      adc_iface_pkg::PH_IDLE:
      begin
        // starts during a conversion are ignored
        if (start_fall)
        begin
          next_st.phase = adc_iface_pkg::PH_BUSY;
          next_st.hold = 1'b1;
          next_st.sample = analog_sample;
          next_st.shreg = {`LEAD_ZEROS, analog_sample};
          next_st.clk_cnt = 6'h00;
          next_st.bit_cnt = 5'h00;
          next_st.xmit = 1'b0;
          next_st.last_bit = 1'b0;
        end
      end
      adc_iface_pkg::PH_BUSY:
      begin
        if (st.xmit && rise_en)
        begin
          next_st.ser.serial_data_out = st.shreg[15];
          next_st.shreg = {st.shreg[14:0], 1'b0};
          if (st.last_bit)
          begin
            next_st.xmit = 1'b0;
            next_st.ser.serial_frame_strobe_n = 1'b1;
          end
        end
        if (fall_en)
        begin
          next_st.clk_cnt = st.clk_cnt + 6'h01;
          if (st.clk_cnt == 6'(STROBE_DELAY - 1))
          begin
            next_st.xmit = 1'b1;
            next_st.ser.serial_frame_strobe_n = 1'b0;
          end
          if (st.xmit && !st.last_bit)
          begin
            next_st.bit_cnt = st.bit_cnt + 5'h01;
            if (st.bit_cnt == 5'(`SERIAL_BITS - 1))
              next_st.last_bit = 1'b1;
          end
          if (st.clk_cnt == 6'(CONV_CLKS - 1))
          begin
            next_st.phase = adc_iface_pkg::PH_IDLE;
            next_st.hold = 1'b0;
            next_st.load = 1'b1;
            next_st.xmit = 1'b0;
            next_st.ser.serial_frame_strobe_n = 1'b1;
          end
        end
      end
      default:
      begin
        next_st.phase = adc_iface_pkg::PH_IDLE;
        next_st.hold = 1'b0;
      end
    endcase

    // end of conversion wins over a read falling in the same cycle
    if (st.load)
      next_st.done_n = 1'b0;

    // host may ignore the hazard of reading mid-conversion; data is the old one
    next_st.bus.low_oe = reading;
    next_st.bus.high_oe = reading & ~ser;
    if (ser)
      next_st.bus.data = {4'h0, byte_lane(result, hbs)};
    else
      next_st.bus.data = result;

    // open drain: enable only while pulling low
    next_st.ser.serial_frame_strobe_oe = ser &
                                         ~next_st.ser.serial_frame_strobe_n;
    next_st.ser.serial_data_oe = ser & next_st.xmit &
                                 ~next_st.ser.serial_data_out;
    next_st.ser.serial_clock = next_st.sclk;
    if (fmt == `FMT_SER_FREE)
      next_st.ser.serial_clock_oe = ~next_st.sclk;
    else if (fmt == `FMT_SER_GATED)
      next_st.ser.serial_clock_oe = next_st.xmit & ~next_st.sclk;
    else
      next_st.ser.serial_clock_oe = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.meta <= `RST_PIN_SYNC;
      st.sync <= `RST_PIN_SYNC;
      st.start_prev <= 1'b1;
      st.done_n <= 1'b1;
      st.ser.serial_frame_strobe_n <= 1'b1;
      st.ser.serial_data_out <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // =====================================================================
  // outputs
  assign track_hold_hold = st.hold;
  assign conversion_done_n = st.done_n;
  assign data_bus = st.bus;
  assign serial_pins = st.ser;

endmodule : adc_host_interface

// >>> adc_host_interface_assertions.sv
// concurrent checks on the converter interface ports
`timescale 1ns/1ps

module adc_host_interface_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host side
  input wire logic convert_start_n,
  input wire adc_iface_pkg::host_pins_t host_pins,
  input wire logic ext_clock_select,
  input wire logic ext_conv_clock,
  input wire logic [11:0] analog_sample,
  // outputs
  input wire logic track_hold_hold,
  input wire logic conversion_done_n,
  input wire adc_iface_pkg::data_bus_t data_bus,
  input wire adc_iface_pkg::serial_pins_t serial_pins
);
  // =====================================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_hold_on_start: assert property (
    $fell(convert_start_n) && !track_hold_hold && conversion_done_n
    |-> ##[1:3] track_hold_hold) else $error("hold not entered");
  a_done_after_busy: assert property (
    $fell(conversion_done_n) |-> $past(track_hold_hold, 3))
    else $error("done without conversion");
  a_done_release: assert property (
    $fell(host_pins.chip_select_n | host_pins.read_n) && !conversion_done_n
    |-> ##[2:4] conversion_done_n) else $error("done not released");
  a_bus_released: assert property (
    (host_pins.chip_select_n | host_pins.read_n)[*4]
    |-> !data_bus.low_oe && !data_bus.high_oe) else $error("bus driven");
  a_word_no_serial: assert property (
    (host_pins.format_select == 2'h1)[*4] |-> !serial_pins.serial_clock_oe
    && !serial_pins.serial_frame_strobe_oe && !serial_pins.serial_data_oe)
    else $error("serial active in word format");
  a_word_full: assert property (
    (host_pins.format_select == 2'h1)[*4] ##0 data_bus.low_oe
    |-> data_bus.high_oe) else $error("word read not full width");
  a_byte_nibble: assert property (
    (host_pins.format_select != 2'h1)[*4] ##0 data_bus.low_oe
    |-> data_bus.data[11:8] == 4'h0 && !data_bus.high_oe)
    else $error("byte read upper nibble");
  a_result_stable: assert property (
    (host_pins.format_select == 2'h1)[*2] ##0 data_bus.low_oe
    && $past(data_bus.low_oe) && $changed(data_bus.data)
    |-> ##1 !conversion_done_n) else $error("result changed early");
  a_strobe_start: assert property (
    $rose(track_hold_hold) && host_pins.format_select != 2'h1
    |-> ##[1:30] serial_pins.serial_frame_strobe_oe)
    else $error("frame strobe late");
  a_free_clock: assert property (
    (host_pins.format_select == 2'h2)[*8]
    |-> !(serial_pins.serial_clock_oe == $past(serial_pins.serial_clock_oe)
    && serial_pins.serial_clock_oe == $past(serial_pins.serial_clock_oe, 2)
    && serial_pins.serial_clock_oe == $past(serial_pins.serial_clock_oe, 3)
    && serial_pins.serial_clock_oe == $past(serial_pins.serial_clock_oe, 4)))
    else $error("serial clock stopped");
endmodule : adc_host_interface_checker

bind adc_host_interface adc_host_interface_checker checker_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .convert_start_n(convert_start_n),
  .host_pins(host_pins), .ext_clock_select(ext_clock_select),
  .ext_conv_clock(ext_conv_clock), .analog_sample(analog_sample),
  .track_hold_hold(track_hold_hold), .conversion_done_n(conversion_done_n),
  .data_bus(data_bus), .serial_pins(serial_pins));

// >>> host_model.sv
// host processor model: timer start pulse and read strobes
`timescale 1ns/1ps

module host_model (
  // clock
  input wire logic ref_clk,
  // host strobes
  output logic convert_start_n,
  output logic chip_select_n,
  output logic read_n,
  output logic high_byte_select
);
  initial
  begin
    convert_start_n = 1'b1;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    high_byte_select = 1'b0;
  end

  // =====================================================================
  // strobes
  task automatic start_pulse();
    @(posedge ref_clk) #1 convert_start_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 convert_start_n = 1'b1;
  endtask : start_pulse

  // callers may read at any time: a read mid-conversion returns the old result
  task automatic read_on(input logic upper);
    @(posedge ref_clk) #1 high_byte_select = upper;
    chip_select_n = 1'b0;
    read_n = 1'b0;
  endtask : read_on

  task automatic read_off();
    @(posedge ref_clk) #1 chip_select_n = 1'b1;
    read_n = 1'b1;
  endtask : read_off
endmodule : host_model

// >>> testbench.sv
// self-checking bench for the converter host interface
`timescale 1ns/1ps

module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] fmt = 2'h1;
  logic ext_sel = 1'b0;
  logic ext_clk = 1'b0;
  logic [11:0] sample = 12'h000;
  logic cs_n, rd_n, hbs, start_n, hold, done_n;
  adc_iface_pkg::host_pins_t pins;
  adc_iface_pkg::data_bus_t bus;
  adc_iface_pkg::serial_pins_t ser;
  logic sclk_d = 1'b1;
  logic strb_d = 1'b0;
  logic [15:0] shift = 16'h0000;
  int nbits = 0;
  int bad_count = 0;
  int n_compared = 0;

  always #25 ref_clk = ~ref_clk;
  always
  begin
    repeat (4) @(posedge ref_clk);
    #1 ext_clk = ~ext_clk;
  end
  assign pins = '{chip_select_n: cs_n, read_n: rd_n,
    high_byte_select: hbs, format_select: fmt};

  // open drain: pin is low while its enable is high
  // a bit counts only on a clock fall while the strobe was already low
  always @(posedge ref_clk)
  begin
    sclk_d <= ~ser.serial_clock_oe;
    strb_d <= ser.serial_frame_strobe_oe;
    if (sclk_d && strb_d && ser.serial_clock_oe)
    begin
      shift <= {shift[14:0], ~ser.serial_data_oe};
      nbits <= nbits + 1;
    end
  end

  host_model host_model_inst (.ref_clk(ref_clk), .convert_start_n(start_n),
    .chip_select_n(cs_n), .read_n(rd_n), .high_byte_select(hbs));
  adc_host_interface adc_host_interface_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .convert_start_n(start_n), .host_pins(pins),
    .ext_clock_select(ext_sel), .ext_conv_clock(ext_clk),
    .analog_sample(sample), .track_hold_hold(hold),
    .conversion_done_n(done_n), .data_bus(bus), .serial_pins(ser));

  // =====================================================================
  // helpers
  task automatic check(input string name, input logic [15:0] got,
    input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wait_done();
    for (int i = 0; i < 400 && done_n !== 1'b0; i++)
      cyc(1);
    check("done low", 16'(done_n), 16'h0000);
  endtask : wait_done

  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // =====================================================================
  // scenarios
  task automatic t_word(input logic [11:0] val);
    fmt = 2'h1;
    sample = val;
    host_model_inst.start_pulse();
    cyc(5);
    check("hold", 16'(hold), 16'h0001);
    check("done busy", 16'(done_n), 16'h0001);
    sample = ~val;
    wait_done();
    for (int k = 0; k < 2; k++)
    begin
      host_model_inst.read_on(1'b0);
      cyc(5);
      check("word", 16'(bus.data), 16'(val));
      check("oe", {14'h0, bus.low_oe, bus.high_oe}, 16'h0003);
      check("done release", 16'(done_n), 16'h0001);
      host_model_inst.read_off();
      cyc(5);
      check("oe off", {14'h0, bus.low_oe, bus.high_oe}, 16'h0000);
    end
  endtask : t_word

  task automatic t_byte(input logic [1:0] f, input logic [11:0] val);
    logic was;
    fmt = f;
    sample = val;
    nbits = 0;
    host_model_inst.start_pulse();
    wait_done();
    check("bits", 16'(nbits), 16'h0010);
    check("serial word", shift, {4'h0, val});
    check("strobe idle", {13'h0, ser.serial_frame_strobe_n,
      ser.serial_frame_strobe_oe, ser.serial_data_oe}, 16'h0004);
    if (f == 2'h0)
      check("gated", 16'(ser.serial_clock_oe), 16'h0000);
    else
    begin
      was = ser.serial_clock_oe;
      cyc(4);
      check("free clock", 16'(ser.serial_clock_oe), {15'h0, ~was});
    end
    host_model_inst.read_on(1'b0);
    cyc(5);
    check("low byte", 16'(bus.data), {8'h00, val[7:0]});
    check("done release", 16'(done_n), 16'h0001);
    host_model_inst.read_off();
    host_model_inst.read_on(1'b1);
    cyc(5);
    check("high byte", 16'(bus.data), {12'h000, val[11:8]});
    host_model_inst.read_off();
    cyc(5);
  endtask : t_byte

  task automatic t_held(input logic [11:0] old, input logic [11:0] val);
    fmt = 2'h1;
    ext_sel = 1'b1;
    sample = val;
    host_model_inst.read_on(1'b0);
    cyc(5);
    host_model_inst.start_pulse();
    cyc(20);
    check("old data", 16'(bus.data), 16'(old));
    wait_done();
    cyc(2);
    check("new data", 16'(bus.data), 16'(val));
    cyc(50);
    check("done held", 16'(done_n), 16'h0000);
    host_model_inst.read_off();
    ext_sel = 1'b0;
    cyc(5);
  endtask : t_held

  initial
  begin
    repeat (4) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    cyc(4);
    check("done reset", 16'(done_n), 16'h0001);
    t_word(12'hA5C);
    t_byte(2'h0, 12'h3B7);
    t_byte(2'h2, 12'hC48);
    t_held(12'hC48, 12'h7E1);
    end_of_test();
  end

  initial
  begin
    #400000;
    bad_count++;
    end_of_test();
  end
endmodule : testbench
